// File: core/smf_pkg.sv
package smf_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam int unsigned SCAN_US = 1000;
  localparam int unsigned SCAN_DIV = CLK_HZ / 1_000_000 * SCAN_US;
  // ****************************************
  // Terminal key and reply codes
  // ****************************************
  localparam logic [7:0] KEY_MODE = 8'h01;
  localparam logic [7:0] KEY_PREV = 8'h02;
  localparam logic [7:0] KEY_RESET = 8'h04;
  localparam logic [7:0] KEY_NEXT = 8'h06;
  localparam logic [7:0] KEY_ENTER = 8'h0d;
  localparam logic [7:0] KEY_ABORT = 8'h1b;
  localparam logic [7:0] KEY_SPACE = 8'h20;
  localparam logic [7:0] KEY_C = 8'h43;
  localparam logic [7:0] KEY_D = 8'h44;
  localparam logic [7:0] KEY_E = 8'h45;
  localparam logic [7:0] KEY_T = 8'h54;
  localparam logic [7:0] CASE_MASK = 8'hdf;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] TXC_NUM = 8'h23;
  localparam logic [7:0] TXC_VAL = 8'h3d;
  localparam logic [7:0] TXC_OK = 8'h2a;
  localparam logic [7:0] TXC_ERR = 8'h21;
  localparam logic [7:0] TXC_FILE = 8'h46;
  localparam logic [7:0] TXC_TRK = 8'h54;
  localparam logic [1:0] CMD_C = 2'h0;
  localparam logic [1:0] CMD_D = 2'h1;
  localparam logic [1:0] CMD_E = 2'h2;
  localparam logic [1:0] CMD_T = 2'h3;
  localparam logic [1:0] SCREEN_LAST = 2'h3;
  localparam logic [2:0] TRK_LAST = 3'h4;
  localparam logic [3:0] LAST_BIT = 4'h9;
  localparam logic [7:0] SYNC_RST = 8'h80;
  localparam int unsigned STAT_FAULT_BIT = 4;
  localparam int unsigned RMS_SHIFT = 4;
  // ****************************************
  // Parameter numbers, bounds and defaults
  // ****************************************
  localparam logic [4:0] P_GAIN = 5'h01;
  localparam logic [4:0] P_KI = 5'h02;
  localparam logic [4:0] P_HALLS = 5'h06;
  localparam logic [4:0] P_RMS_THR = 5'h10;
  localparam logic [4:0] P_RMS_TIME = 5'h11;
  localparam logic [4:0] P_VERR_LIM = 5'h12;
  localparam logic [4:0] P_THERM_EN = 5'h15;
  localparam logic [31:0] NUM_MAX = 32'h0000001f;
  localparam logic [31:0] MAX_LONG = 32'h7fffffff;
  localparam logic [31:0] DEF_GAIN = 32'h000b71b0;
  localparam logic [31:0] DEF_KI = 32'h000088b8;
  localparam logic [31:0] DEF_RMS_THR = 32'h00004000;
  localparam logic [31:0] MAX_RMS_THR = 32'h0000ffff;
  localparam logic [31:0] DEF_RMS_TIME = 32'h00000064;
  localparam logic [31:0] MAX_RMS_TIME = 32'h00002710;
  localparam logic [31:0] DEF_VERR = 32'h000003e8;
  localparam logic [31:0] ONE = 32'h00000001;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_VEL = 12'h008;
  localparam logic [11:0] A_VERR = 12'h00c;
  localparam logic [11:0] A_CMD = 12'h010;
  localparam logic [11:0] A_GAIN = 12'h014;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    S_TRACK = 3'b000,
    S_PARAMS = 3'b001,
    S_CNUM = 3'b010,
    S_CVAL = 3'b011,
    S_XFER = 3'b100
  } smf_menu_e;
  typedef struct packed {
    logic amp;
    logic therm;
    logic enc;
    logic verr;
    logic rms;
    logic hall;
  } smf_fault_s;
  typedef struct packed {
    logic [4:0] num;
    logic [31:0] value;
  } smf_nvw_s;
endpackage

// File: core/smf_supervisor.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module smf_supervisor
  import smf_pkg::*;
#(
  parameter int unsigned BAUD_CYC = BAUD_DIV,
  parameter int unsigned SCAN_CYC = SCAN_DIV
)
(
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic rxd, // Serial in
  output logic txd, // Serial out
  input wire logic [2:0] hall, // Hall sensors
  input wire logic enc_present, // Encoder detected
  input wire logic enc_invalid, // Bad encoder signals
  input wire logic therm_hot, // Motor too hot
  input wire logic amp_fault, // Power stage fault
  input wire logic init_no_hall, // Halless init running
  input wire logic signed [15:0] velocity, // Measured velocity
  input wire logic signed [15:0] vel_error, // Velocity error
  input wire logic signed [15:0] cur_cmd, // Current command
  output logic drive_reset, // Drive reset pulse
  output logic stage_enable, // Power stage enable
  output logic led_green, // Indicator green
  output logic led_red, // Indicator red
  output logic [7:0] status_word, // Status word
  output logic [31:0] proportional_gain, // Gain in effect
  output logic halls_avail, // Halls used, reset-effective
  output logic remote_mode, // Remote mode active
  output logic nv_wr_valid, // Storage write pulse
  output smf_nvw_s nv_wr // Storage write data
);
  localparam logic [15:0] BAUD_LAST = 16'(BAUD_CYC - 1);
  localparam logic [15:0] BAUD_HALF = 16'(BAUD_CYC / 2);
  localparam logic [19:0] SCAN_LAST = 20'(SCAN_CYC - 1);

  // ****************************************
  // Parameter table
  // ****************************************
  function automatic logic [31:0] p_def(input logic [4:0] n);
    case (n)
      P_GAIN: p_def = DEF_GAIN;
      P_KI: p_def = DEF_KI;
      P_HALLS, P_THERM_EN: p_def = ONE;
      P_RMS_THR: p_def = DEF_RMS_THR;
      P_RMS_TIME: p_def = DEF_RMS_TIME;
      P_VERR_LIM: p_def = DEF_VERR;
      default: p_def = '0;
    endcase
  endfunction

  function automatic logic [31:0] p_max(input logic [4:0] n);
    case (n)
      P_GAIN, P_KI, P_VERR_LIM: p_max = MAX_LONG;
      P_HALLS, P_THERM_EN: p_max = ONE;
      P_RMS_THR: p_max = MAX_RMS_THR;
      P_RMS_TIME: p_max = MAX_RMS_TIME;
      default: p_max = '0;
    endcase
  endfunction

  function automatic logic p_valid(input logic [4:0] n);
    p_valid = (n == P_GAIN) || (n == P_KI) || (n == P_HALLS) ||
      (n == P_RMS_THR) || (n == P_RMS_TIME) || (n == P_VERR_LIM) ||
      (n == P_THERM_EN);
  endfunction

  function automatic logic [15:0] absv(input logic signed [15:0] v);
    absv = v[15] ? 16'(-v) : 16'(v);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic rx_in;
  logic [2:0] hall_s;
  logic encp_s, enci_s, therm_s, amp_s;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end
    else
    begin
      sync1_reg <= {rxd, hall, enc_present, enc_invalid, therm_hot,
        amp_fault};
      sync2_reg <= sync1_reg;
    end
  assign {rx_in, hall_s, encp_s, enci_s, therm_s, amp_s} = sync2_reg;

  // ****************************************
  // Serial receiver and transmitter
  // ****************************************
  logic rx_busy, rx_valid, tx_busy, tx_go, tx_pend;
  logic [15:0] rx_cnt, tx_cnt;
  logic [3:0] rx_bit, tx_bit;
  logic [7:0] rx_sh, tx_data, tx_pbyte, trk_b;
  logic [9:0] tx_sh;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_busy <= 1'b0;
      rx_valid <= 1'b0;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
    end
    else
    begin
      rx_valid <= 1'b0;
      if (!rx_busy)
      begin
        if (!rx_in)
        begin
          rx_busy <= 1'b1;
          rx_cnt <= BAUD_HALF;
          rx_bit <= '0;
        end
      end
      else if (rx_cnt != '0)
        rx_cnt <= rx_cnt - 16'h0001;
      else
      begin
        rx_cnt <= BAUD_LAST;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == '0)
          rx_busy <= !rx_in;
        else if (rx_bit != LAST_BIT)
          rx_sh <= {rx_in, rx_sh[7:1]};
        else
        begin
          rx_busy <= 1'b0;
          rx_valid <= rx_in;
        end
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tx_busy <= 1'b0;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '1;
      txd <= 1'b1;
    end
    else if (!tx_busy)
    begin
      if (tx_go)
      begin
        tx_busy <= 1'b1;
        tx_sh <= {1'b1, tx_data, 1'b0};
        tx_cnt <= BAUD_LAST;
        tx_bit <= '0;
        txd <= 1'b0;
      end
    end
    else if (tx_cnt != '0)
      tx_cnt <= tx_cnt - 16'h0001;
    else
    begin
      tx_cnt <= BAUD_LAST;
      tx_bit <= tx_bit + 4'h1;
      tx_sh <= {1'b1, tx_sh[9:1]};
      txd <= tx_sh[1];
      if (tx_bit == LAST_BIT)
      begin
        tx_busy <= 1'b0;
        txd <= 1'b1;
      end
    end

  // ****************************************
  // Menu interpreter
  // ****************************************
  smf_menu_e menu_reg;
  logic [1:0] sel_reg, screen_reg, run_cmd;
  logic [4:0] num_reg;
  logic [31:0] acc_reg;
  logic [35:0] acc_wide;
  logic ovf_reg, menu_key, is_dig, run, val_ok, num_ok, commit;
  logic [7:0] ukey;
  logic [31:0] prm_reg [0:31];
  smf_fault_s faults_reg;

  assign ukey = rx_sh & CASE_MASK;
  assign is_dig = (rx_sh >= CH_0) && (rx_sh <= CH_9);
  assign menu_key = rx_valid && !remote_mode && rx_sh != KEY_RESET &&
    rx_sh != KEY_MODE;
  assign acc_wide = {4'h0, acc_reg} * 36'h00000000a + 36'(rx_sh[3:0]);
  assign val_ok = !ovf_reg && acc_reg <= p_max(num_reg) &&
    acc_reg >= ((num_reg == P_RMS_TIME) ? ONE : '0);
  assign num_ok = !ovf_reg && acc_reg <= NUM_MAX && p_valid(acc_reg[4:0]);
  assign commit = menu_key && menu_reg == S_CVAL && rx_sh == KEY_ENTER &&
    val_ok;

  always_comb
  begin
    run = 1'b1;
    run_cmd = sel_reg;
    if (ukey == KEY_C)
      run_cmd = CMD_C;
    else if (ukey == KEY_D)
      run_cmd = CMD_D;
    else if (ukey == KEY_E)
      run_cmd = CMD_E;
    else if (ukey == KEY_T)
      run_cmd = CMD_T;
    else if (rx_sh != KEY_ENTER)
      run = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      menu_reg <= S_TRACK;
      sel_reg <= CMD_C;
      screen_reg <= '0;
      remote_mode <= 1'b0;
      num_reg <= '0;
      acc_reg <= '0;
      ovf_reg <= 1'b0;
      tx_pend <= 1'b0;
      tx_pbyte <= '0;
    end
    else
    begin
      if (tx_go && tx_pend)
        tx_pend <= 1'b0;
      if (rx_valid && rx_sh == KEY_RESET)
      begin
        menu_reg <= S_TRACK;
        sel_reg <= CMD_C;
      end
      else if (rx_valid && rx_sh == KEY_MODE)
        remote_mode <= !remote_mode;
      else if (menu_key)
      begin
        unique case (menu_reg)
          S_TRACK: menu_reg <= S_PARAMS;
          S_PARAMS:
            if (rx_sh == KEY_ABORT)
              menu_reg <= S_TRACK;
            else if (rx_sh == KEY_PREV)
              screen_reg <= screen_reg - 2'h1;
            else if (rx_sh == KEY_NEXT)
              screen_reg <= screen_reg + 2'h1;
            else if (rx_sh == KEY_SPACE)
              sel_reg <= sel_reg + 2'h1;
            else if (run)
            begin
              sel_reg <= run_cmd;
              acc_reg <= '0;
              ovf_reg <= 1'b0;
              tx_pend <= run_cmd != CMD_D;
              unique case (run_cmd)
                CMD_C:
                begin
                  menu_reg <= S_CNUM;
                  tx_pbyte <= TXC_NUM;
                end
                CMD_D: menu_reg <= S_TRACK;
                CMD_E: tx_pbyte <= 8'(faults_reg);
                CMD_T:
                begin
                  menu_reg <= S_XFER;
                  tx_pbyte <= TXC_FILE;
                end
              endcase
            end
          S_CNUM, S_CVAL:
            if (rx_sh == KEY_ABORT)
              menu_reg <= S_PARAMS;
            else if (is_dig)
            begin
              acc_reg <= acc_wide[31:0];
              ovf_reg <= ovf_reg || (acc_wide[35:32] != '0);
            end
            else if (rx_sh == KEY_ENTER)
            begin
              tx_pend <= 1'b1;
              acc_reg <= '0;
              ovf_reg <= 1'b0;
              if (menu_reg == S_CNUM && num_ok)
              begin
                menu_reg <= S_CVAL;
                num_reg <= acc_reg[4:0];
                tx_pbyte <= TXC_VAL;
              end
              else
              begin
                menu_reg <= S_PARAMS;
                tx_pbyte <= commit ? TXC_OK : TXC_ERR;
              end
            end
          S_XFER:
            if (rx_sh == KEY_ABORT || rx_sh == KEY_ENTER)
              menu_reg <= S_PARAMS;
          default: menu_reg <= S_PARAMS;
        endcase
      end
    end

  // ****************************************
  // Tracking stream
  // ****************************************
  logic [2:0] trk_idx;
  logic trk_on;

  assign trk_on = menu_reg == S_TRACK && !remote_mode;
  assign tx_go = !tx_busy && (tx_pend || trk_on);
  assign tx_data = tx_pend ? tx_pbyte : trk_b;

  always_comb
  begin
    case (trk_idx)
      3'h0: trk_b = TXC_TRK;
      3'h1: trk_b = status_word;
      3'h2: trk_b = velocity[7:0];
      3'h3: trk_b = vel_error[7:0];
      default: trk_b = cur_cmd[7:0];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trk_idx <= '0;
    else if (!trk_on)
      trk_idx <= '0;
    else if (tx_go && !tx_pend)
      trk_idx <= (trk_idx == TRK_LAST) ? 3'h0 : trk_idx + 3'h1;

  // ****************************************
  // Parameter store
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
        prm_reg[i] <= p_def(5'(i));
      nv_wr_valid <= 1'b0;
      nv_wr <= '0;
    end
    else
    begin
      nv_wr_valid <= commit;
      if (commit)
      begin
        prm_reg[num_reg] <= acc_reg;
        nv_wr <= '{num: num_reg, value: acc_reg};
      end
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      drive_reset <= 1'b0;
      halls_avail <= ONE[0];
    end
    else
    begin
      drive_reset <= rx_valid && rx_sh == KEY_RESET;
      if (drive_reset)
        halls_avail <= prm_reg[P_HALLS][0];
    end
  assign proportional_gain = prm_reg[P_GAIN];

  // ****************************************
  // Fault monitor
  // ****************************************
  logic [19:0] scan_cnt;
  logic tick, ctrl_en;
  logic [15:0] avg_reg, rms_cnt;
  logic signed [16:0] avg_diff;
  smf_fault_s found;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      scan_cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= scan_cnt == SCAN_LAST;
      scan_cnt <= (scan_cnt == SCAN_LAST) ? '0 : scan_cnt + 20'h00001;
    end

  assign avg_diff = $signed({1'b0, absv(cur_cmd)}) -
    $signed({1'b0, avg_reg});

  always_comb
  begin
    found.hall = (hall_s == 3'b000 || hall_s == 3'b111) &&
      !init_no_hall;
    found.rms = rms_cnt >= prm_reg[P_RMS_TIME][15:0];
    found.verr = 32'(absv(vel_error)) > prm_reg[P_VERR_LIM];
    found.enc = !encp_s || enci_s;
    found.therm = therm_s && prm_reg[P_THERM_EN][0];
    found.amp = amp_s;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      avg_reg <= '0;
      rms_cnt <= '0;
    end
    else if (tick)
    begin
      avg_reg <= avg_reg + 16'(avg_diff >>> RMS_SHIFT);
      if (avg_reg <= prm_reg[P_RMS_THR][15:0])
        rms_cnt <= '0;
      else if (rms_cnt != '1)
        rms_cnt <= rms_cnt + 16'h0001;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      faults_reg <= '0;
    else
      faults_reg <= (drive_reset ? '0 : faults_reg) |
        (tick ? found : '0);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      status_word <= '0;
      stage_enable <= 1'b0;
      led_green <= 1'b0;
      led_red <= 1'b1;
    end
    else
    begin
      status_word <= 8'(|faults_reg) << STAT_FAULT_BIT;
      stage_enable <= ctrl_en && !(|faults_reg);
      led_green <= ctrl_en && !(|faults_reg);
      led_red <= !ctrl_en || (|faults_reg);
    end

  // ****************************************
  // APB slave
  // ****************************************
  logic apb_err;

  assign pready = 1'b1;
  assign pslverr = psel && penable && apb_err;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_en <= 1'b0;
    else if (psel && penable && pwrite && paddr == A_CTRL)
      ctrl_en <= pwdata[0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata <= '0;
      apb_err <= 1'b0;
    end
    else if (psel && !penable)
    begin
      apb_err <= 1'b0;
      case (paddr)
        A_CTRL: prdata <= 32'(ctrl_en);
        A_STATUS: prdata <= 32'({remote_mode, menu_reg, screen_reg,
          sel_reg, status_word, 2'b00, faults_reg});
        A_VEL: prdata <= 32'(velocity);
        A_VERR: prdata <= 32'(vel_error);
        A_CMD: prdata <= 32'(cur_cmd);
        A_GAIN: prdata <= proportional_gain;
        default:
        begin
          prdata <= '0;
          apb_err <= 1'b1;
        end
      endcase
    end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_key_c;
    menu_key && menu_reg == S_PARAMS && ukey == KEY_C;
  endsequence
  sequence s_bad_value;
    menu_key && menu_reg == S_CVAL && rx_sh == KEY_ENTER && !val_ok;
  endsequence

  a_led_fault_red: assert property (|faults_reg |=> led_red &&
    !led_green && !stage_enable) else $error("fault not shown red");
  a_track_any_key: assert property (menu_key && menu_reg == S_TRACK
    |=> menu_reg == S_PARAMS) else $error("track key ignored");
  a_change_prompt: assert property (s_key_c |=> menu_reg == S_CNUM
    && tx_pend && tx_pbyte == TXC_NUM) else $error("no change prompt");
  a_commit_store: assert property (commit |=> nv_wr_valid &&
    prm_reg[nv_wr.num] == nv_wr.value) else $error("value not stored");
  a_range_reject: assert property (s_bad_value |=> !nv_wr_valid
    && tx_pbyte == TXC_ERR && menu_reg == S_PARAMS)
    else $error("bad value accepted");
  a_halls_hold: assert property (!drive_reset |=>
    $stable(halls_avail)) else $error("halls changed without reset");
  a_screen_wrap: assert property (menu_key && menu_reg == S_PARAMS &&
    rx_sh == KEY_NEXT && screen_reg == SCREEN_LAST |=> screen_reg == '0)
    else $error("screen did not wrap");
  a_fault_latch: assert property (|faults_reg && !drive_reset
    |=> |faults_reg) else $error("fault lost without reset");
  a_status_bit: assert property (##1 status_word[STAT_FAULT_BIT] ==
    $past(|faults_reg)) else $error("status bit wrong");
  a_hall_fault: assert property (tick && found.hall |=>
    faults_reg.hall [*2]) else $error("hall fault not raised");
endmodule
`default_nettype wire

// File: tb/servo_menu_fault_supervisor_bench.sv
`timescale 1ns/100ps
`default_nettype none
module servo_menu_fault_supervisor_bench;
  import smf_pkg::*;
  localparam int B = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd;
  logic enc_present, enc_invalid, therm_hot, amp_fault, init_no_hall;
  logic drive_reset, stage_enable, led_green, led_red, halls_avail;
  logic remote_mode, nv_wr_valid, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, proportional_gain, rd;
  logic [2:0] hall;
  logic [7:0] status_word, last;
  logic signed [15:0] vel;
  smf_nvw_s nv_wr, nvs;
  int cnt, err_count, checked;
  smf_supervisor #(.BAUD_CYC(B), .SCAN_CYC(64)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .hall(hall),
    .enc_present(enc_present), .enc_invalid(enc_invalid),
    .therm_hot(therm_hot), .amp_fault(amp_fault),
    .init_no_hall(init_no_hall), .velocity(vel), .vel_error(vel),
    .cur_cmd(vel), .drive_reset(drive_reset), .stage_enable(stage_enable),
    .led_green(led_green), .led_red(led_red), .status_word(status_word),
    .proportional_gain(proportional_gain), .halls_avail(halls_avail),
    .remote_mode(remote_mode), .nv_wr_valid(nv_wr_valid), .nv_wr(nv_wr));
  smf_term #(.BIT(B)) i_term (.clk(pclk), .txd(txd), .rxd(rxd),
    .last(last), .cnt(cnt));
  always #5 pclk = ~pclk;
  always @(posedge pclk)
    if (nv_wr_valid === 1'b1)
      nvs <= nv_wr;
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [36:0] e, g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
      if (s == "timeout")
        end_of_test();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("timeout", 1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic keyq(input logic [7:0] b);
    i_term.send(b);
    repeat (12 * B) @(posedge pclk);
  endtask
  task automatic byt;
    int n, t;
    n = cnt;
    t = 0;
    while (cnt == n && t < 40 * B)
    begin
      @(posedge pclk);
      t++;
    end
    chk("timeout", 0, t / (40 * B));
  endtask
  task automatic key(input logic [7:0] b, e);
    i_term.send(b);
    byt();
    chk("reply", e, last);
  endtask
  task automatic chg(input logic [7:0] n, v, e);
    key(KEY_C, TXC_NUM);
    keyq(n);
    key(KEY_ENTER, TXC_VAL);
    keyq(v);
    key(KEY_ENTER, e);
  endtask
  task automatic t_regs;
    chk("gain", DEF_GAIN, proportional_gain);
    chk("status", 0, status_word);
    chk("red", 1, led_red);
    apb(1'b1, A_CTRL, ONE);
    repeat (2) @(posedge pclk);
    chk("green", 1, led_green);
    chk("enable", 1, stage_enable);
    apb(1'b0, 12'hffc, 0);
    chk("slverr", 1, er);
    apb(1'b0, A_GAIN, 0);
    chk("gain rd", DEF_GAIN, rd);
  endtask
  task automatic t_menu;
    keyq(KEY_SPACE);
    apb(1'b0, A_STATUS, 0);
    chk("menu", S_PARAMS, rd[22:20]);
    keyq(KEY_SPACE);
    keyq(KEY_PREV);
    apb(1'b0, A_STATUS, 0);
    chk("cmd", CMD_D, rd[17:16]);
    chk("screen", SCREEN_LAST, rd[19:18]);
    keyq(KEY_NEXT);
    apb(1'b0, A_STATUS, 0);
    chk("wrap", 0, rd[19:18]);
    key(KEY_T, TXC_FILE);
    keyq(KEY_ENTER);
    chg(8'h31, 8'h35, TXC_OK);
    chk("gain", 32'h5, proportional_gain);
    chk("store", {P_GAIN, 32'h5}, nvs);
    chg(8'h36, 8'h32, TXC_ERR);
    key(KEY_C, TXC_NUM);
    keyq(KEY_ABORT);
    apb(1'b0, A_STATUS, 0);
    chk("abort", S_PARAMS, rd[22:20]);
    chg(8'h36, 8'h30, TXC_OK);
    chk("halls", 1, halls_avail);
  endtask
  task automatic t_fault;
    hall <= 3'b000;
    repeat (200) @(posedge pclk);
    chk("fault", 8'h10, status_word);
    chk("stage", 0, stage_enable);
    chk("red", 1, led_red);
    hall <= 3'b101;
    repeat (200) @(posedge pclk);
    chk("latched", 8'h10, status_word);
    keyq(KEY_RESET);
    chk("cleared", 0, status_word);
    chk("halls", 0, halls_avail);
  endtask
  task automatic t_track;
    int i;
    i = 0;
    do
    begin
      byt();
      i++;
    end
    while (last != TXC_TRK && i < 6);
    chk("trk tag", TXC_TRK, last);
    byt();
    chk("trk status", 0, last);
    byt();
    chk("trk vel", vel[7:0], last);
  endtask
  task automatic t_flt;
    init_no_hall <= 1'b1;
    hall <= 3'b111;
    repeat (200) @(posedge pclk);
    chk("no hall", 0, status_word);
    hall <= 3'b101;
    repeat (4) @(posedge pclk);
    init_no_hall <= 1'b0;
    {enc_present, therm_hot, amp_fault} <= 3'b011;
    vel <= 16'sh7000;
    repeat (9000) @(posedge pclk);
    apb(1'b0, A_STATUS, 0);
    chk("faults", 6'h3e, rd[5:0]);
    keyq(KEY_SPACE);
    key(KEY_E, 8'h3e);
    {enc_present, therm_hot, amp_fault} <= 3'b100;
    vel <= 16'sh0010;
    repeat (1000) @(posedge pclk);
    keyq(KEY_RESET);
    chk("clear", 0, status_word);
    chk("green", 1, led_green);
  endtask
  task automatic t_remote;
    keyq(KEY_MODE);
    chk("remote", 1, remote_mode);
    keyq(KEY_SPACE);
    apb(1'b0, A_STATUS, 0);
    chk("remote key", {1'b1, S_TRACK}, rd[23:20]);
    keyq(KEY_MODE);
    chk("local", 0, remote_mode);
  endtask
  initial
  begin
    {pclk, presetn, psel, penable, pwrite} = 0;
    {enc_invalid, therm_hot, amp_fault, init_no_hall} = 0;
    enc_present = 1'b1;
    hall = 3'b101;
    vel = 16'sh0010;
    paddr = 12'h000;
    pwdata = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_menu();
    t_fault();
    t_track();
    t_flt();
    t_remote();
    end_of_test();
  end
endmodule
`default_nettype wire

// File: tb/smf_term.sv
`timescale 1ns/100ps
`default_nettype none
module smf_term #(
  parameter int BIT = 16
)
(
  input wire logic clk, // Clock
  input wire logic txd, // Device serial out
  output logic rxd, // Device serial in
  output logic [7:0] last, // Last byte heard
  output int cnt // Bytes heard
);
  initial
  begin
    rxd = 1'b1;
    last = 8'h00;
    cnt = 0;
  end
  // Receiver samples mid-bit
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clk);
      last[i] <= txd;
    end
    repeat (BIT) @(posedge clk);
    cnt <= cnt + 1;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire
